// file: pkg/radio_link_pkg.sv
package radio_link_pkg;
    localparam logic [6:0] OFF_STATUS = 7'h00;
    localparam logic [6:0] OFF_OP = 7'h04;
    localparam logic [6:0] OFF_POWER = 7'h05;
    localparam logic [6:0] OFF_SETUP = 7'h06;
    localparam logic [6:0] OFF_CHANNEL = 7'h07;
    localparam logic [6:0] OFF_TIMING = 7'h08;
    localparam logic [6:0] OFF_STRENGTH = 7'h09;
    localparam logic [6:0] OFF_ACK = 7'h0b;
    localparam logic [6:0] OFF_RETRY_SETUP = 7'h0c;
    localparam logic [6:0] OFF_RETRY_COUNT = 7'h0d;
    localparam logic [6:0] OFF_ADDR0 = 7'h0e;
    localparam logic [6:0] OFF_ADDR1 = 7'h0f;
    localparam logic [6:0] OFF_ADDR2 = 7'h10;

    localparam int BIT_EXHAUSTED = 5;
    localparam int BIT_WHITEN_OFF = 5;
    localparam int BIT_RELAUNCH = 3;
    localparam int BIT_CONT = 2;
    localparam int BIT_START = 1;
    localparam int BIT_DIR = 0;
    localparam int BIT_POWER_DOWN = 1;
    localparam int BIT_STANDBY = 0;
    localparam int BIT_CAL = 5;
    localparam int BIT_MEASURE = 4;
    localparam int BIT_ACK_OFF = 4;
    localparam int SPI_WRITE_BIT = 7;

    localparam logic [5:0] RST_OP = 6'h00;
    localparam logic [1:0] RST_POWER = 2'h0;
    localparam logic [5:0] RST_SETUP = 6'h16;
    localparam logic [5:0] RST_CHANNEL = 6'h00;
    localparam logic [7:0] RST_TIMING = 8'had;
    localparam logic [4:0] RST_ACK = 5'h0d;
    localparam logic [7:0] RST_RETRY_SETUP = 8'h73;
    localparam logic [23:0] RST_ADDR = 24'h00000f;
    localparam logic [3:0] COUNT_MAX = 4'hf;

    localparam int CLOCK_MHZ = 200;
    localparam int RETRY_STEP_US = 250;
    localparam logic [15:0] RETRY_STEP_CYCLES =
        16'(RETRY_STEP_US * CLOCK_MHZ);

    typedef struct packed {
        logic whitening_off;
        logic receive_relaunch;
        logic direction_select;
        logic deep_power_down;
        logic low_power_standby;
        logic [2:0] output_level;
        logic [5:0] radio_channel_number;
        logic [3:0] startup_duration;
        logic [3:0] turnaround_duration;
        logic auto_ack_off;
        logic [3:0] ack_wait_limit;
        logic [23:0] self_address;
    } radio_ctrl_s;

    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic [7:0] data;
    } reg_write_s;
endpackage

// file: logic/spi_reg_port.sv
`timescale 1ns/1ps
// serial access: command byte {write, addr[6:0]}, then data bytes,
// address steps by one per byte; mode 0, msb first
module spi_reg_port
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic sck_i,
    input wire logic cs_b_i,
    input wire logic sdi_i,
    input wire logic [7:0] rd_data_i,
    output logic [6:0] rd_addr_o,
    output radio_link_pkg::reg_write_s wr_o,
    output logic sdo_o,
    output logic sdo_oe_o
);
    logic [2:0] sck_sync_reg;
    logic [2:0] cs_sync_reg;
    logic [2:0] sdi_sync_reg;
    logic sck_lvl_reg;
    logic cs_lvl_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic [7:0] tx_shift_reg;
    logic in_data_reg;
    logic is_write_reg;
    logic load_reg;
    logic sck_rise;
    logic sck_fall;
    logic [7:0] byte_in;

    // second and third stage must agree before a level counts
    assign sck_rise = (sck_sync_reg[1] == sck_sync_reg[2]) &&
        sck_sync_reg[2] && !sck_lvl_reg;
    assign sck_fall = (sck_sync_reg[1] == sck_sync_reg[2]) &&
        !sck_sync_reg[2] && sck_lvl_reg;
    assign byte_in = {shift_reg, sdi_sync_reg[2]};

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            sck_sync_reg <= 3'h0;
            cs_sync_reg <= 3'h7;
            sdi_sync_reg <= 3'h0;
            sck_lvl_reg <= 1'b0;
            cs_lvl_reg <= 1'b1;
        end
        else
        begin
            sck_sync_reg <= {sck_sync_reg[1:0], sck_i};
            cs_sync_reg <= {cs_sync_reg[1:0], cs_b_i};
            sdi_sync_reg <= {sdi_sync_reg[1:0], sdi_i};
            if (sck_sync_reg[1] == sck_sync_reg[2])
                sck_lvl_reg <= sck_sync_reg[2];
            if (cs_sync_reg[1] == cs_sync_reg[2])
                cs_lvl_reg <= cs_sync_reg[2];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            in_data_reg <= 1'b0;
            is_write_reg <= 1'b0;
            rd_addr_o <= 7'h00;
            wr_o <= '0;
            load_reg <= 1'b0;
        end
        else
        begin
            wr_o.valid <= 1'b0;
            if (cs_lvl_reg)
            begin
                bit_cnt_reg <= 3'h0;
                in_data_reg <= 1'b0;
                load_reg <= 1'b0;
            end
            else if (sck_rise)
            begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                shift_reg <= byte_in[6:0];
                if (bit_cnt_reg == 3'h7)
                begin
                    if (!in_data_reg)
                    begin
                        in_data_reg <= 1'b1;
                        is_write_reg <= byte_in[radio_link_pkg::SPI_WRITE_BIT];
                        rd_addr_o <= byte_in[6:0];
                    end
                    else
                    begin
                        wr_o.valid <= is_write_reg;
                        wr_o.addr <= rd_addr_o;
                        wr_o.data <= byte_in;
                        rd_addr_o <= rd_addr_o + 7'h01;
                    end
                    load_reg <= 1'b1;
                end
            end
            else if (sck_fall)
                load_reg <= 1'b0;
        end
    end

    // read byte is fetched at the first falling edge of a byte
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            tx_shift_reg <= 8'h00;
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
        end
        else
        begin
            sdo_oe_o <= !cs_lvl_reg;
            if (sck_fall && !cs_lvl_reg)
            begin
                if (load_reg && !is_write_reg)
                begin
                    sdo_o <= rd_data_i[7];
                    tx_shift_reg <= {rd_data_i[6:0], 1'b0};
                end
                else
                begin
                    sdo_o <= tx_shift_reg[7];
                    tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                end
            end
        end
    end
endmodule // spi_reg_port

// file: logic/sat_counter.sv
`timescale 1ns/1ps
// four-bit saturating counter; a count in the clearing cycle gives one
module sat_counter
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic clear_i,
    input wire logic inc_i,
    output logic [3:0] count_o
);
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            count_o <= 4'h0;
        else if (clear_i)
            count_o <= {3'h0, inc_i};
        else if (inc_i && count_o != radio_link_pkg::COUNT_MAX)
            count_o <= count_o + 4'h1;
    end
endmodule // sat_counter

// file: logic/radio_link_control_regs.sv
`timescale 1ns/1ps
module radio_link_control_regs
#(
    parameter logic [15:0] RETRY_STEP_CYCLES =
        radio_link_pkg::RETRY_STEP_CYCLES
)
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic spi_sck_i,
    input wire logic spi_cs_b_i,
    input wire logic spi_sdi_i,
    output logic spi_sdo_o,
    output logic spi_sdo_oe_o,
    input wire logic packet_start_i,
    input wire logic ack_missing_i,
    input wire logic rssi_valid_i,
    input wire logic [3:0] rssi_level_i,
    input wire logic calibration_done_i,
    output radio_link_pkg::radio_ctrl_s ctrl_o,
    output logic continuous_transmit_o,
    output logic radio_launch_o,
    output logic synth_calibration_go_o,
    output logic strength_measure_go_o,
    output logic retransmit_go_o,
    output logic retry_exhausted_flag_o
);
    typedef enum logic [0:0] {RETRY_IDLE, RETRY_WAIT} retry_state_e;

    radio_link_pkg::reg_write_s wr;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic [5:0] op_reg;
    logic [1:0] power_reg;
    logic [5:0] setup_reg;
    logic [5:0] channel_reg;
    logic [7:0] timing_reg;
    logic measure_reg;
    logic [3:0] strength_result;
    logic [4:0] ack_reg;
    logic [7:0] retry_setup_reg;
    logic [23:0] self_address;
    logic [3:0] lost_packet_count;
    logic [3:0] retry_count;
    retry_state_e retry_state_reg;
    logic [3:0] delay_steps_reg;
    logic [15:0] step_cnt_reg;
    logic retry_fire;
    logic lost_event;
    logic wr_op;
    logic wr_setup;
    logic wr_channel;
    logic wr_status;
    logic [3:0] retry_delay;
    logic [3:0] retry_limit;

    assign wr_op = wr.valid && wr.addr == radio_link_pkg::OFF_OP;
    assign wr_setup = wr.valid && wr.addr == radio_link_pkg::OFF_SETUP;
    assign wr_channel = wr.valid && wr.addr == radio_link_pkg::OFF_CHANNEL;
    assign wr_status = wr.valid && wr.addr == radio_link_pkg::OFF_STATUS;
    assign retry_delay = retry_setup_reg[7:4];
    assign retry_limit = retry_setup_reg[3:0];

    spi_reg_port u_spi
    (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .sck_i(spi_sck_i),
        .cs_b_i(spi_cs_b_i),
        .sdi_i(spi_sdi_i),
        .rd_data_i(rd_data),
        .rd_addr_o(rd_addr),
        .wr_o(wr),
        .sdo_o(spi_sdo_o),
        .sdo_oe_o(spi_sdo_oe_o)
    );

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            op_reg <= radio_link_pkg::RST_OP;
        else if (wr_op)
            op_reg <= wr.data[5:0];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            radio_launch_o <= 1'b0;
        else
            radio_launch_o <= wr_op && wr.data[radio_link_pkg::BIT_START];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            continuous_transmit_o <= 1'b0;
        else
            continuous_transmit_o <= op_reg[radio_link_pkg::BIT_CONT] &&
                op_reg[radio_link_pkg::BIT_DIR];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            power_reg <= radio_link_pkg::RST_POWER;
        else if (wr.valid && wr.addr == radio_link_pkg::OFF_POWER)
            power_reg <= wr.data[1:0];
    end

    // calibration bit reads one until the synthesizer is done
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            setup_reg <= radio_link_pkg::RST_SETUP;
        else if (wr_setup)
            setup_reg <= wr.data[5:0];
        else if (calibration_done_i)
            setup_reg[radio_link_pkg::BIT_CAL] <= 1'b0;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            synth_calibration_go_o <= 1'b0;
        else
            synth_calibration_go_o <= wr_setup &&
                wr.data[radio_link_pkg::BIT_CAL];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            channel_reg <= radio_link_pkg::RST_CHANNEL;
        else if (wr_channel)
            channel_reg <= wr.data[5:0];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            timing_reg <= radio_link_pkg::RST_TIMING;
        else if (wr.valid && wr.addr == radio_link_pkg::OFF_TIMING)
            timing_reg <= wr.data;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            measure_reg <= 1'b0;
            strength_measure_go_o <= 1'b0;
            strength_result <= 4'h0;
        end
        else
        begin
            strength_measure_go_o <= 1'b0;
            if (wr.valid && wr.addr == radio_link_pkg::OFF_STRENGTH)
            begin
                measure_reg <= wr.data[radio_link_pkg::BIT_MEASURE];
                strength_measure_go_o <= wr.data[radio_link_pkg::BIT_MEASURE];
            end
            if (rssi_valid_i)
                strength_result <= rssi_level_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            ack_reg <= radio_link_pkg::RST_ACK;
        else if (wr.valid && wr.addr == radio_link_pkg::OFF_ACK)
            ack_reg <= wr.data[4:0];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            retry_setup_reg <= radio_link_pkg::RST_RETRY_SETUP;
        else if (wr.valid && wr.addr == radio_link_pkg::OFF_RETRY_SETUP)
            retry_setup_reg <= wr.data;
    end

    // own address bytes, low byte first
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            self_address <= radio_link_pkg::RST_ADDR;
        else if (wr.valid)
        begin
            case (wr.addr)
                radio_link_pkg::OFF_ADDR0: self_address[7:0] <= wr.data;
                radio_link_pkg::OFF_ADDR1: self_address[15:8] <= wr.data;
                radio_link_pkg::OFF_ADDR2: self_address[23:16] <= wr.data;
                default: self_address <= self_address;
            endcase
        end
    end

    // retry engine: a missed ack waits (delay+1) steps, then retransmits;
    // a new packet aborts the wait so stale retries never go out
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            retry_state_reg <= RETRY_IDLE;
            delay_steps_reg <= 4'h0;
            step_cnt_reg <= 16'h0000;
        end
        else if (packet_start_i)
            retry_state_reg <= RETRY_IDLE;
        else
        begin
            case (retry_state_reg)
                RETRY_IDLE:
                begin
                    step_cnt_reg <= 16'h0000;
                    delay_steps_reg <= retry_delay;
                    if (ack_missing_i && !ack_reg[radio_link_pkg::BIT_ACK_OFF]
                        && retry_count < retry_limit)
                        retry_state_reg <= RETRY_WAIT;
                end
                RETRY_WAIT:
                begin
                    if (step_cnt_reg == RETRY_STEP_CYCLES - 16'h0001)
                    begin
                        step_cnt_reg <= 16'h0000;
                        delay_steps_reg <= delay_steps_reg - 4'h1;
                        if (delay_steps_reg == 4'h0)
                            retry_state_reg <= RETRY_IDLE;
                    end
                    else
                        step_cnt_reg <= step_cnt_reg + 16'h0001;
                end
                default: retry_state_reg <= RETRY_IDLE;
            endcase
        end
    end

    assign retry_fire = !packet_start_i && retry_state_reg == RETRY_WAIT &&
        step_cnt_reg == RETRY_STEP_CYCLES - 16'h0001 &&
        delay_steps_reg == 4'h0;
    // limit reached means the packet is lost
    assign lost_event = ack_missing_i && !packet_start_i &&
        retry_state_reg == RETRY_IDLE &&
        !ack_reg[radio_link_pkg::BIT_ACK_OFF] && retry_count >= retry_limit;

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            retransmit_go_o <= 1'b0;
        else
            retransmit_go_o <= retry_fire;
    end

    // lost count saturates, cleared by channel write
    sat_counter u_lost
    (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .clear_i(wr_channel),
        .inc_i(lost_event),
        .count_o(lost_packet_count)
    );

    // retry count restarts with each packet
    sat_counter u_retry
    (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .clear_i(packet_start_i),
        .inc_i(retry_fire),
        .count_o(retry_count)
    );

    // set on exhaustion, write one clears, set wins
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            retry_exhausted_flag_o <= 1'b0;
        else if (lost_event)
            retry_exhausted_flag_o <= 1'b1;
        else if (wr_status && wr.data[radio_link_pkg::BIT_EXHAUSTED])
            retry_exhausted_flag_o <= 1'b0;
    end

    always_comb
    begin
        case (rd_addr)
            radio_link_pkg::OFF_STATUS:
                rd_data = {2'h0, retry_exhausted_flag_o, 5'h00};
            radio_link_pkg::OFF_OP: rd_data = {2'h0, op_reg};
            radio_link_pkg::OFF_POWER: rd_data = {6'h00, power_reg};
            radio_link_pkg::OFF_SETUP: rd_data = {2'h0, setup_reg};
            radio_link_pkg::OFF_CHANNEL: rd_data = {2'h0, channel_reg};
            radio_link_pkg::OFF_TIMING: rd_data = timing_reg;
            radio_link_pkg::OFF_STRENGTH:
                rd_data = {3'h0, measure_reg, strength_result};
            radio_link_pkg::OFF_ACK: rd_data = {3'h0, ack_reg};
            radio_link_pkg::OFF_RETRY_SETUP: rd_data = retry_setup_reg;
            radio_link_pkg::OFF_RETRY_COUNT:
                rd_data = {lost_packet_count, retry_count};
            radio_link_pkg::OFF_ADDR0: rd_data = self_address[7:0];
            radio_link_pkg::OFF_ADDR1: rd_data = self_address[15:8];
            radio_link_pkg::OFF_ADDR2: rd_data = self_address[23:16];
            default: rd_data = 8'h00;
        endcase
    end

    // control outputs; fields straight from register flops
    assign ctrl_o.whitening_off = op_reg[radio_link_pkg::BIT_WHITEN_OFF];
    assign ctrl_o.receive_relaunch = op_reg[radio_link_pkg::BIT_RELAUNCH];
    assign ctrl_o.direction_select = op_reg[radio_link_pkg::BIT_DIR];
    assign ctrl_o.deep_power_down = power_reg[radio_link_pkg::BIT_POWER_DOWN];
    assign ctrl_o.low_power_standby = power_reg[radio_link_pkg::BIT_STANDBY];
    assign ctrl_o.output_level = setup_reg[2:0];
    assign ctrl_o.radio_channel_number = channel_reg;
    assign ctrl_o.startup_duration = timing_reg[7:4];
    assign ctrl_o.turnaround_duration = timing_reg[3:0];
    assign ctrl_o.auto_ack_off = ack_reg[radio_link_pkg::BIT_ACK_OFF];
    assign ctrl_o.ack_wait_limit = ack_reg[3:0];
    assign ctrl_o.self_address = self_address;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    start_launch_a: assert property (
        wr_op && wr.data[radio_link_pkg::BIT_START] |=> radio_launch_o)
        else $error("start write did not launch");
    cont_transmit_a: assert property (
        continuous_transmit_o |-> $past(op_reg[radio_link_pkg::BIT_DIR]))
        else $error("continuous transmit outside transmit mode");
    power_switch_a: assert property (
        wr.valid && wr.addr == radio_link_pkg::OFF_POWER |=>
        ctrl_o.deep_power_down == $past(wr.data[1]) &&
        ctrl_o.low_power_standby == $past(wr.data[0]))
        else $error("power switches not taken");
    cal_start_a: assert property (
        wr_setup && wr.data[radio_link_pkg::BIT_CAL] |=>
        synth_calibration_go_o)
        else $error("calibration not started");
    strength_latch_a: assert property (
        rssi_valid_i |=> strength_result == $past(rssi_level_i))
        else $error("measurement result not captured");
    lost_hold_a: assert property (
        lost_packet_count == 4'hf && !wr_channel |=>
        lost_packet_count == 4'hf)
        else $error("lost count left saturation");
    lost_clear_a: assert property (
        wr_channel && !lost_event |=> lost_packet_count == 4'h0)
        else $error("channel write kept lost count");
    retry_clear_a: assert property (
        packet_start_i |=> retry_count == 4'h0)
        else $error("retry count not cleared on new packet");
    retry_bound_a: assert property (
        retransmit_go_o |-> retry_count <= retry_limit && retry_count != 0)
        else $error("retransmit beyond limit");
    flag_set_a: assert property (
        lost_event |=> retry_exhausted_flag_o)
        else $error("exhaustion flag not set");
    flag_clear_a: assert property (
        wr_status && wr.data[5] && !lost_event |=> !retry_exhausted_flag_o)
        else $error("write one did not clear flag");

    launch_seen_c: cover property (radio_launch_o);
    retransmit_seen_c: cover property (retransmit_go_o);
    exhausted_seen_c: cover property ($rose(retry_exhausted_flag_o));
    lost_full_c: cover property (lost_packet_count == 4'hf);
endmodule // radio_link_control_regs

// file: verification/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model
(
    input wire logic clock_i,
    input wire logic sdo_i,
    output logic sck_o = 1'b0,
    output logic cs_b_o = 1'b1,
    output logic sdi_o = 1'b0
);
    // sck halves of 8 clocks, four times the two a level needs to count
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        @(posedge clock_i);
        cs_b_o <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            repeat (8) @(posedge clock_i);
            sck_o <= 1'b0;
            sdi_o <= tx[i];
            repeat (8) @(posedge clock_i);
            sck_o <= 1'b1;
            rx = {rx[6:0], sdo_i};
        end
        repeat (8) @(posedge clock_i);
        sck_o <= 1'b0;
        repeat (8) @(posedge clock_i);
        cs_b_o <= 1'b1;
        // released data line must not keep its last level
        sdi_o <= ~sdi_o;
        repeat (8) @(posedge clock_i);
    endtask
endmodule // spi_host_model

// file: verification/tb_radio_link_control_regs.sv
`timescale 1ns/1ps
module tb_radio_link_control_regs;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [3:0] ev = 4'h0;
    logic [3:0] lvl = 4'h0;
    logic sck, cs_b, sdi, sdo, oe, cont, flag;
    logic [3:0] go;
    radio_link_pkg::radio_ctrl_s c;
    logic [7:0] r;
    int err_total = 0;
    int num_checks = 0;
    int n[4] = '{0, 0, 0, 0};
    // pulled up while the device leaves it undriven
    wire logic miso = oe ? sdo : 1'b1;
    initial
    begin
        forever #2.5 clock_i = ~clock_i;
    end
    radio_link_control_regs #(.RETRY_STEP_CYCLES(16'h0004)) dut_u
    (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .spi_sck_i(sck),
        .spi_cs_b_i(cs_b), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
        .spi_sdo_oe_o(oe), .packet_start_i(ev[0]), .ack_missing_i(ev[1]),
        .rssi_valid_i(ev[2]), .rssi_level_i(lvl),
        .calibration_done_i(ev[3]), .ctrl_o(c),
        .continuous_transmit_o(cont), .radio_launch_o(go[0]),
        .synth_calibration_go_o(go[1]), .strength_measure_go_o(go[2]),
        .retransmit_go_o(go[3]), .retry_exhausted_flag_o(flag)
    );
    spi_host_model host_u
    (
        .clock_i(clock_i), .sdo_i(miso), .sck_o(sck), .cs_b_o(cs_b),
        .sdi_o(sdi)
    );
    always @(posedge clock_i)
    begin
        for (int k = 0; k < 4; k++)
            n[k] += int'(go[k] === 1'b1);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer({1'b1, a, d}, r);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        host_u.xfer({1'b0, a, 8'h00}, r);
        chk(r, exp);
    endtask
    task automatic pulse(input int k);
        @(posedge clock_i);
        ev[k] <= 1'b1;
        @(posedge clock_i);
        ev <= 4'h0;
        repeat (2) @(posedge clock_i);
    endtask
    task automatic t_reset();
        rd(7'h06, 8'h16);
        rd(7'h08, 8'had);
        rd(7'h0b, 8'h0d);
        rd(7'h0c, 8'h73);
        rd(7'h0e, 8'h0f);
        rd(7'h04, 8'h00);
        rd(7'h0a, 8'h00);
        $display("reset values done");
    endtask
    task automatic t_ctrl();
        wr(7'h04, 8'h07);
        chk(8'(n[0]), 8'h01);
        chk({7'h0, cont}, 8'h01);
        chk({7'h0, c.direction_select}, 8'h01);
        wr(7'h04, 8'h2c);
        chk({6'h0, c.whitening_off, c.receive_relaunch}, 8'h03);
        chk({7'h0, cont}, 8'h00);
        wr(7'h08, 8'hf8);
        chk({4'h0, c.startup_duration}, 8'h0f);
        chk({4'h0, c.turnaround_duration}, 8'h08);
        wr(7'h05, 8'hff);
        rd(7'h05, 8'h03);
        chk({6'h0, c.deep_power_down, c.low_power_standby}, 8'h03);
        $display("control done");
    endtask
    task automatic t_event();
        wr(7'h06, 8'h37);
        chk(8'(n[1]), 8'h01);
        chk({5'h0, c.output_level}, 8'h07);
        pulse(3);
        rd(7'h06, 8'h17);
        wr(7'h09, 8'h10);
        chk(8'(n[2]), 8'h01);
        lvl <= 4'ha;
        pulse(2);
        rd(7'h09, 8'h1a);
        $display("events done");
    endtask
    task automatic t_retry();
        wr(7'h0c, 8'h01);
        pulse(0);
        pulse(1);
        repeat (8) @(posedge clock_i);
        chk(8'(n[3]), 8'h01);
        pulse(1);
        chk({7'h0, flag}, 8'h01);
        rd(7'h0d, 8'h11);
        wr(7'h00, 8'h20);
        chk({7'h0, flag}, 8'h00);
        wr(7'h07, 8'h05);
        chk({2'h0, c.radio_channel_number}, 8'h05);
        rd(7'h0d, 8'h01);
        pulse(0);
        rd(7'h0d, 8'h00);
        // delay code 1 is two steps of four cycles from the missed ack
        wr(7'h0c, 8'h13);
        pulse(1);
        repeat (6) @(posedge clock_i);
        chk(8'(n[3]), 8'h01);
        repeat (2) @(posedge clock_i);
        chk(8'(n[3]), 8'h02);
        wr(7'h0c, 8'h00);
        repeat (16)
        begin
            pulse(0);
            pulse(1);
        end
        rd(7'h0d, 8'hf0);
        chk(8'(n[3]), 8'h02);
        wr(7'h0b, 8'h18);
        chk({3'h0, c.auto_ack_off, c.ack_wait_limit}, 8'h18);
        wr(7'h00, 8'h20);
        pulse(1);
        chk({7'h0, flag}, 8'h00);
        $display("retry done");
    endtask
    task automatic t_addr();
        wr(7'h0e, 8'h5f);
        wr(7'h10, 8'h3c);
        chk(c.self_address[23:16], 8'h3c);
        chk(c.self_address[7:0], 8'h5f);
        rd(7'h0e, 8'h5f);
        $display("address done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clock_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_ctrl();
        t_event();
        t_retry();
        t_addr();
        final_report();
    end
    initial
    begin
        #300us;
        err_total++;
        final_report();
    end
endmodule // tb_radio_link_control_regs
